// ---- verilog/dcf_pkg.sv ----
// Package of constants for the daisy comms fault supervisor
// Functional notes
// - Pending fault: read gives fault then data
// - Host clears data registers, then status zero
// - No fault response after clear unless refault
// - Watchdog only active when daisy chained
// - Low range codes: 1 to 63 seconds
// - High range codes: 2 to 128 minutes
// - Zero code needs setup password first
// - Nonzero to nonzero change needs no password
// - Expiry sets expired flag, enters sleep
// - Watchdog fault drives fault low, no response
// - Watchdog stops counting at expiry until a command restarts it
// - Every command except no-op restarts watchdog
// - Wait for response from device above
// - Missing response sends comms failure with address
// - Relay failure from above; data on read
// - Ports forced idle at communication end; fault responses do not force idle
// - Host sends all ones, then ACK
// - Host sleeps, waits, wakes the stack
// - Four bit scan counter wraps on overflow
// - Busy scan ignored but still counted
// - Host reads every fault status on fault
// - Fault output low until all cleared
package dcf_pkg;
   localparam logic [5:0] REG_FAULT_STATUS = 6'h04;
   localparam logic [5:0] REG_DEVICE_SETUP = 6'h19;
   localparam logic [5:0] REG_WDOG_BAL = 6'h15;
   localparam logic [5:0] REG_SCAN_COUNT = 6'h16;
   localparam logic [5:0] REG_FAULT_DATA = 6'h00;
   localparam logic [5:0] SETUP_PASSWORD = 6'h3a;
   localparam logic [13:0] CLEAR_VALUE = 14'h0000;
   localparam int WDG_BIT = 6;
   localparam int CODE_MSB = 6;
   localparam int PW_LSB = 8;
   localparam int SECONDS_PER_STEP_LO = 1;
   localparam int SECONDS_PER_STEP_HI = 120;
   localparam int HI_OFFSET = 63;
   localparam int CLK_HZ = 250000000;
   // Command codes on the request channel
   typedef enum logic [2:0] {
      DCF_CMD_READ = 3'h0,
      DCF_CMD_WRITE = 3'h1,
      DCF_CMD_SCAN = 3'h2,
      DCF_CMD_MEASURE = 3'h3,
      DCF_CMD_ACTION = 3'h4,
      DCF_CMD_RESET = 3'h5,
      DCF_CMD_NOOP = 3'h6
   } dcf_cmd_e;
   // Response kinds on the answer channel
   typedef enum logic [2:0] {
      DCF_RSP_ACK = 3'h0,
      DCF_RSP_DATA = 3'h1,
      DCF_RSP_FAULT = 3'h2,
      DCF_RSP_COMMFAIL = 3'h3,
      DCF_RSP_NAK = 3'h4
   } dcf_rsp_e;
endpackage : dcf_pkg

// ---- verilog/dcf_link_if.sv ----
// Interface joining the host end and the device end
`timescale 1ns/10ps
interface dcf_link_if;
   logic req_valid;
   logic [2:0] req_cmd;
   logic [5:0] req_addr;
   logic [13:0] req_wdata;
   logic req_all;
   logic rsp_valid;
   logic [2:0] rsp_kind;
   logic [13:0] rsp_data;
   logic [3:0] rsp_stack_addr;
   logic fault_n;
   modport dev (input req_valid, input req_cmd, input req_addr,
      input req_wdata, input req_all, output rsp_valid, output rsp_kind,
      output rsp_data, output rsp_stack_addr, output fault_n);
   modport host (output req_valid, output req_cmd, output req_addr,
      output req_wdata, output req_all, input rsp_valid, input rsp_kind,
      input rsp_data, input rsp_stack_addr, input fault_n);
endinterface : dcf_link_if

// ---- verilog/dcf_wdog_timer.sv ----
// Watchdog timer with two-range timeout code
`timescale 1ns/10ps
module dcf_wdog_timer #(
   parameter int TICKS_PER_SEC = dcf_pkg::CLK_HZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [6:0] code,
   input wire logic enable,
   input wire logic restart,
   output logic expire
);
   localparam int SECW = 32;
   logic [SECW-1:0] tick_q;
   logic [15:0] secs_q;
   logic [15:0] limit;
   logic armed_q;
   // Timeout in seconds from the code
   always_comb
   begin
      if (code[dcf_pkg::CODE_MSB])
         limit = 16'((int'(code) - dcf_pkg::HI_OFFSET) *
            dcf_pkg::SECONDS_PER_STEP_HI);
      else
         limit = 16'(int'(code) * dcf_pkg::SECONDS_PER_STEP_LO);
   end
   // Second prescaler and second counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_q <= '0;
         secs_q <= '0;
         armed_q <= 1'b0;
         expire <= 1'b0;
      end
      else
      begin
         expire <= 1'b0;
         if (restart || !enable)
         begin
            tick_q <= '0;
            secs_q <= '0;
            armed_q <= enable;
         end
         else if (armed_q)
         begin
            if (tick_q == SECW'(TICKS_PER_SEC - 1))
            begin
               tick_q <= '0;
               if (secs_q + 16'h0001 >= limit)
               begin
                  expire <= 1'b1;
                  armed_q <= 1'b0;
               end
               else
                  secs_q <= secs_q + 16'h0001;
            end
            else
               tick_q <= tick_q + SECW'(1);
         end
      end
   end
endmodule : dcf_wdog_timer

// ---- verilog/dcf_device.sv ----
// Device end: watchdog, fault response, comms failure, scan counter
`timescale 1ns/10ps
module dcf_device #(
   parameter int TICKS_PER_SEC = dcf_pkg::CLK_HZ,
   parameter int RSP_TIMEOUT_BASE = 1000,
   parameter int RSP_TIMEOUT_STEP = 100,
   parameter logic [3:0] STACK_ADDR = 4'h1
) (
   input wire logic pclk,
   input wire logic presetn,
   dcf_link_if.dev link,
   input wire logic daisy_mode,
   input wire logic top_device,
   input wire logic fault_event,
   input wire logic above_rsp,
   input wire logic above_commfail,
   input wire logic scan_done,
   output logic sleeping,
   output logic scan_busy,
   output logic port_idle_force,
   output logic [3:0] scan_count
);
   logic [13:0] fault_status_q;
   logic [13:0] fault_data_q;
   logic [13:0] wdog_bal_q;
   logic [13:0] setup_q;
   logic fault_sent_q;
   logic wait_q;
   logic [15:0] wait_cnt_q;
   logic is_read_q;
   logic expire;
   logic req_is_read;
   logic req_is_write;
   logic req_is_scan;
   logic req_valid_sync;
   logic clr_hit;
   logic [5:0] addr_q;
   localparam logic [15:0] RSP_LIMIT =
      16'(RSP_TIMEOUT_BASE + RSP_TIMEOUT_STEP * int'(STACK_ADDR));
   assign req_is_read = link.req_valid && link.req_cmd == dcf_pkg::DCF_CMD_READ;
   assign req_is_write = link.req_valid &&
      link.req_cmd == dcf_pkg::DCF_CMD_WRITE;
   assign req_is_scan = link.req_valid &&
      (link.req_cmd == dcf_pkg::DCF_CMD_SCAN ||
       link.req_cmd == dcf_pkg::DCF_CMD_MEASURE);
   assign req_valid_sync = link.req_valid &&
      link.req_cmd != dcf_pkg::DCF_CMD_NOOP;
   // Status clear counts only once the fault data is already zero
   assign clr_hit = req_is_write &&
      link.req_addr == dcf_pkg::REG_FAULT_STATUS &&
      link.req_wdata == dcf_pkg::CLEAR_VALUE &&
      fault_data_q == dcf_pkg::CLEAR_VALUE;
   // Watchdog runs only in daisy chain and nonzero code
   dcf_wdog_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_wdog (
      .pclk(pclk),
      .presetn(presetn),
      .code(wdog_bal_q[6:0]),
      .enable(daisy_mode && wdog_bal_q[6:0] != 7'h00),
      .restart(req_valid_sync),
      .expire(expire)
   );
   // Registers written by the host
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wdog_bal_q <= 14'h0001;
         setup_q <= '0;
         fault_data_q <= '0;
      end
      else
      begin
         if (fault_event)
            fault_data_q <= 14'h0001;
         else if (req_is_write && link.req_addr == dcf_pkg::REG_FAULT_DATA)
            fault_data_q <= link.req_wdata;
         if (req_is_write && link.req_addr == dcf_pkg::REG_DEVICE_SETUP)
            setup_q <= link.req_wdata;
         if (req_is_write && link.req_addr == dcf_pkg::REG_WDOG_BAL)
         begin
            if (link.req_wdata[6:0] != 7'h00)
               wdog_bal_q <= link.req_wdata;
            else if (setup_q[13:dcf_pkg::PW_LSB] == dcf_pkg::SETUP_PASSWORD)
               wdog_bal_q <= link.req_wdata;
            else
               wdog_bal_q <= {link.req_wdata[13:7], wdog_bal_q[6:0]};
         end
      end
   end
   // Fault status; hardware set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_status_q <= '0;
      else
      begin
         logic [13:0] nxt;
         nxt = fault_status_q;
         if (clr_hit)
            nxt = '0;
         if (fault_event)
            nxt[0] = 1'b1;
         if (expire)
            nxt[dcf_pkg::WDG_BIT] = 1'b1;
         fault_status_q <= nxt;
      end
   end
   // Sleep, fault output, scan activity
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sleeping <= 1'b0;
         link.fault_n <= 1'b1;
         scan_busy <= 1'b0;
         scan_count <= 4'h0;
      end
      else
      begin
         if (expire)
            sleeping <= 1'b1;
         link.fault_n <= !(fault_status_q != 14'h0000 || fault_event ||
            expire || fault_data_q != 14'h0000);
         if (req_is_scan)
            scan_count <= scan_count + 4'h1;
         if (req_is_scan && !sleeping)
            scan_busy <= 1'b1;
         else if (scan_done)
            scan_busy <= 1'b0;
      end
   end
   // Responses: fault, comms failure, normal
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link.rsp_valid <= 1'b0;
         link.rsp_kind <= dcf_pkg::DCF_RSP_ACK;
         link.rsp_data <= '0;
         link.rsp_stack_addr <= STACK_ADDR;
         fault_sent_q <= 1'b0;
         wait_q <= 1'b0;
         wait_cnt_q <= '0;
         is_read_q <= 1'b0;
         addr_q <= '0;
         port_idle_force <= 1'b0;
      end
      else
      begin
         link.rsp_valid <= 1'b0;
         port_idle_force <= 1'b0;
         if (fault_status_q == 14'h0000)
            fault_sent_q <= 1'b0;
         if ((req_is_read || req_is_write) && !top_device)
         begin
            wait_q <= 1'b1;
            wait_cnt_q <= '0;
            is_read_q <= req_is_read;
            addr_q <= link.req_addr;
         end
         if (link.req_valid && fault_status_q != 14'h0000 && !clr_hit)
         begin
            link.rsp_valid <= req_is_read || req_is_write;
            link.rsp_kind <= dcf_pkg::DCF_RSP_FAULT;
            link.rsp_data <= req_is_read ? REG_VALUE(link.req_addr) :
               fault_status_q;
            fault_sent_q <= 1'b1;
         end
         else if (link.req_valid && (top_device || !(req_is_read ||
            req_is_write)))
         begin
            link.rsp_valid <= !req_is_scan &&
               link.req_cmd != dcf_pkg::DCF_CMD_RESET;
            link.rsp_kind <= req_is_read ? dcf_pkg::DCF_RSP_DATA :
               dcf_pkg::DCF_RSP_ACK;
            link.rsp_data <= REG_VALUE(link.req_addr);
            port_idle_force <= 1'b1;
         end
         else if (wait_q && (above_rsp || above_commfail))
         begin
            wait_q <= 1'b0;
            link.rsp_valid <= 1'b1;
            link.rsp_kind <= above_commfail ? dcf_pkg::DCF_RSP_COMMFAIL :
               (is_read_q ? dcf_pkg::DCF_RSP_DATA : dcf_pkg::DCF_RSP_ACK);
            link.rsp_data <= above_commfail && !is_read_q ? 14'h0000 :
               REG_VALUE(addr_q);
            port_idle_force <= 1'b1;
         end
         else if (wait_q && wait_cnt_q == RSP_LIMIT)
         begin
            wait_q <= 1'b0;
            link.rsp_valid <= 1'b1;
            link.rsp_kind <= dcf_pkg::DCF_RSP_COMMFAIL;
            link.rsp_stack_addr <= STACK_ADDR;
            port_idle_force <= 1'b1;
         end
         else if (wait_q)
            wait_cnt_q <= wait_cnt_q + 16'h0001;
         else if (fault_status_q != 14'h0000 && !fault_sent_q &&
            !fault_status_q[dcf_pkg::WDG_BIT])
         begin
            link.rsp_valid <= 1'b1;
            link.rsp_kind <= dcf_pkg::DCF_RSP_FAULT;
            link.rsp_data <= fault_status_q;
            fault_sent_q <= 1'b1;
         end
      end
   end
   // Register read mux
   function automatic logic [13:0] REG_VALUE(input logic [5:0] a);
      case (a)
         dcf_pkg::REG_FAULT_STATUS: REG_VALUE = fault_status_q;
         dcf_pkg::REG_FAULT_DATA: REG_VALUE = fault_data_q;
         dcf_pkg::REG_WDOG_BAL: REG_VALUE = wdog_bal_q;
         dcf_pkg::REG_SCAN_COUNT: REG_VALUE = {10'h000, scan_count};
         dcf_pkg::REG_DEVICE_SETUP: REG_VALUE = setup_q;
         default: REG_VALUE = 14'h0000;
      endcase
   endfunction : REG_VALUE
endmodule : dcf_device

// ---- verilog/dcf_host.sv ----
// Host end: APB command registers driving the link
`timescale 1ns/10ps
module dcf_host (
   input wire logic pclk,
   input wire logic presetn,
   dcf_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_RSP = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   logic [1:0] fault_sync_q;
   logic [31:0] rsp_q;
   logic rsp_new_q;
   // Response capture and fault pin synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_sync_q <= 2'b11;
         rsp_q <= '0;
         rsp_new_q <= 1'b0;
      end
      else
      begin
         fault_sync_q <= {fault_sync_q[0], link.fault_n};
         if (link.rsp_valid)
         begin
            rsp_q <= {7'h00, link.rsp_stack_addr, link.rsp_kind,
               4'h0, link.rsp_data};
            rsp_new_q <= 1'b1;
         end
         else if (psel && penable && !pwrite && paddr == A_RSP)
            rsp_new_q <= 1'b0;
      end
   end
   // APB slave; command word issues one request pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         link.req_valid <= 1'b0;
         link.req_cmd <= 3'h6;
         link.req_addr <= '0;
         link.req_wdata <= '0;
         link.req_all <= 1'b0;
      end
      else
      begin
         link.req_valid <= 1'b0;
         pready <= psel && !pready;
         pslverr <= 1'b0;
         if (psel && !pready)
         begin
            pslverr <= paddr != A_CMD && paddr != A_RSP && paddr != A_STAT;
            if (pwrite && paddr == A_CMD)
            begin
               link.req_valid <= 1'b1;
               link.req_cmd <= pwdata[30:28];
               link.req_all <= pwdata[31];
               link.req_addr <= pwdata[21:16];
               link.req_wdata <= pwdata[13:0];
            end
            case (paddr)
               A_RSP: prdata <= rsp_q;
               A_STAT: prdata <= {30'h0, rsp_new_q, !fault_sync_q[1]};
               default: prdata <= '0;
            endcase
         end
      end
   end
endmodule : dcf_host

// ---- tb/dcf_link_props.sv ----
// Concurrent checks on the link between the host end and the device end
`timescale 1ns/10ps
module dcf_link_props #(
   parameter int RSP_TIMEOUT_BASE = 1000,
   parameter int RSP_TIMEOUT_STEP = 100,
   parameter logic [3:0] STACK_ADDR = 4'h1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req_valid,
   input wire logic [2:0] req_cmd,
   input wire logic [5:0] req_addr,
   input wire logic [13:0] req_wdata,
   input wire logic req_all,
   input wire logic rsp_valid,
   input wire logic [2:0] rsp_kind,
   input wire logic [13:0] rsp_data,
   input wire logic [3:0] rsp_stack_addr,
   input wire logic fault_n
);
   localparam int TO = RSP_TIMEOUT_BASE + RSP_TIMEOUT_STEP * STACK_ADDR;
   localparam int MAXW = TO + 4;
   logic rd_req;
   logic wr_req;
   logic clr_req;
   logic act_req;
   logic scn_req;
   // Request decode
   assign rd_req = req_valid && req_cmd == dcf_pkg::DCF_CMD_READ;
   assign wr_req = req_valid && req_cmd == dcf_pkg::DCF_CMD_WRITE;
   assign act_req = req_valid && req_cmd == dcf_pkg::DCF_CMD_ACTION;
   assign scn_req = req_valid && (req_cmd == dcf_pkg::DCF_CMD_SCAN ||
      req_cmd == dcf_pkg::DCF_CMD_MEASURE);
   assign clr_req = wr_req && req_addr == dcf_pkg::REG_FAULT_STATUS &&
      req_wdata == dcf_pkg::CLEAR_VALUE;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_quiet;
      !rsp_valid [*4];
   endsequence
   sequence s_fault_ans;
      rsp_valid && rsp_kind == dcf_pkg::DCF_RSP_FAULT;
   endsequence
   AST_RD_FAULT: assert property (!fault_n && rd_req |=> s_fault_ans)
      else $error("read during fault not answered with fault");
   AST_WR_FAULT: assert property (!fault_n && wr_req && !clr_req
      |=> s_fault_ans) else $error("write during fault not answered");
   AST_ACT_QUIET: assert property (!fault_n && act_req |=> s_quiet)
      else $error("action during fault was answered");
   AST_CLR_ACK: assert property (!fault_n && clr_req
      |=> rsp_valid && rsp_kind == dcf_pkg::DCF_RSP_ACK)
      else $error("fault clear not acknowledged");
   AST_CLR_ONLY: assert property ($rose(fault_n)
      |-> $past(clr_req) || $past(clr_req, 2))
      else $error("fault output released without clear");
   AST_SCAN_QUIET: assert property (scn_req |=> !rsp_valid)
      else $error("scan or measure was answered");
   AST_ANS_BOUND: assert property (rd_req || wr_req
      |-> ##[1:MAXW] rsp_valid) else $error("read or write left unanswered");
   AST_CF_ADDR: assert property (rsp_valid &&
      rsp_kind == dcf_pkg::DCF_RSP_COMMFAIL && ($past(req_valid, TO) ||
      $past(req_valid, TO + 1) || $past(req_valid, TO + 2))
      |-> rsp_stack_addr == STACK_ADDR) else $error("failure address wrong");
endmodule : dcf_link_props

// ---- tb/tb.sv ----
// Self-checking bench joining the host end and the device end
`timescale 1ns/10ps
module tb;
   localparam logic [20:0] KM = 21'h01c000;
   localparam logic [20:0] AM = 21'h1e0000;
   localparam logic [20:0] E_ACK = {4'h0, dcf_pkg::DCF_RSP_ACK, 14'h0000};
   localparam logic [20:0] E_DAT = {4'h0, dcf_pkg::DCF_RSP_DATA, 14'h0000};
   localparam logic [20:0] E_FLT = {4'h0, dcf_pkg::DCF_RSP_FAULT, 14'h0000};
   localparam logic [20:0] E_CF = {4'h5, dcf_pkg::DCF_RSP_COMMFAIL, 14'h0};
   localparam dcf_pkg::dcf_cmd_e RD = dcf_pkg::DCF_CMD_READ;
   localparam dcf_pkg::dcf_cmd_e WR = dcf_pkg::DCF_CMD_WRITE;
   localparam logic [5:0] WB = dcf_pkg::REG_WDOG_BAL;
   localparam logic [5:0] SCN = dcf_pkg::REG_SCAN_COUNT;
   localparam logic [5:0] FS = dcf_pkg::REG_FAULT_STATUS;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic daisy_mode, top_device, fault_event, above_rsp, above_commfail;
   logic scan_done, sleeping, scan_busy, port_idle_force;
   logic [3:0] scan_count;
   logic [20:0] rq[$];
   int fails, samples_checked, idle_cnt, sc, n;
   dcf_link_if lnk ();
   dcf_device #(.TICKS_PER_SEC(10), .RSP_TIMEOUT_BASE(20),
      .RSP_TIMEOUT_STEP(3), .STACK_ADDR(4'h5)) dcf_device_inst (
      .pclk(pclk), .presetn(presetn), .link(lnk), .daisy_mode(daisy_mode),
      .top_device(top_device), .fault_event(fault_event),
      .above_rsp(above_rsp), .above_commfail(above_commfail),
      .scan_done(scan_done), .sleeping(sleeping), .scan_busy(scan_busy),
      .port_idle_force(port_idle_force), .scan_count(scan_count));
   dcf_host dcf_host_inst (.pclk(pclk), .presetn(presetn), .link(lnk),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   dcf_link_props #(.RSP_TIMEOUT_BASE(20), .RSP_TIMEOUT_STEP(3),
      .STACK_ADDR(4'h5)) dcf_link_props_inst (.pclk(pclk),
      .presetn(presetn), .req_valid(lnk.req_valid), .req_cmd(lnk.req_cmd),
      .req_addr(lnk.req_addr), .req_wdata(lnk.req_wdata),
      .req_all(lnk.req_all), .rsp_valid(lnk.rsp_valid),
      .rsp_kind(lnk.rsp_kind), .rsp_data(lnk.rsp_data),
      .rsp_stack_addr(lnk.rsp_stack_addr), .fault_n(lnk.fault_n));
   // Clock of 4 ns period
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Capture every answer on the link and every idle forcing
   always @(posedge pclk)
   begin
      if (presetn && lnk.rsp_valid === 1'b1)
         rq.push_back({lnk.rsp_stack_addr, lnk.rsp_kind, lnk.rsp_data});
      if (port_idle_force === 1'b1)
         idle_cnt++;
   end
   task automatic close_out();
      if (fails == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   // Wait for the next link answer and compare its masked fields
   task automatic chk_rsp(input logic [20:0] exp, input logic [20:0] m);
      int i;
      i = 0;
      while (rq.size() == 0 && i < 200)
      begin
         @(posedge pclk);
         i++;
      end
      if (rq.size() == 0)
         chk_val(32'h1, 32'h0);
      else
         chk_val({11'h0, rq.pop_front() & m}, {11'h0, exp & m});
   endtask : chk_rsp
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic cmd(input dcf_pkg::dcf_cmd_e c, input logic [5:0] a,
      input logic [13:0] d);
      apb(1'b1, 8'h00, {c == dcf_pkg::DCF_CMD_SCAN, c, 6'h00, a, 2'h0, d});
   endtask : cmd
   task automatic xfer(input dcf_pkg::dcf_cmd_e c, input logic [5:0] a,
      input logic [13:0] d, input logic [20:0] exp, input logic [20:0] m);
      cmd(c, a, d);
      chk_rsp(exp, m);
   endtask : xfer
   task automatic rst();
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rq.delete();
      @(posedge pclk);
   endtask : rst
   // Expiry time of one timeout code, measured from a restarting scan
   task automatic wdog(input logic [6:0] code, input int ticks);
      int i;
      rst();
      xfer(WR, WB, 14'h0005, E_ACK, KM);
      xfer(WR, WB, {7'h00, code}, E_ACK, KM);
      xfer(RD, WB, 14'h0, E_DAT | code, KM | 21'h7f);
      daisy_mode <= 1'b1;
      cmd(dcf_pkg::DCF_CMD_SCAN, 6'h00, 14'h0);
      i = 0;
      while (sleeping !== 1'b1 && i < ticks + 10)
      begin
         @(posedge pclk);
         i++;
      end
      chk_val(32'(i > ticks - 5 && i < ticks + 4), 32'h1);
      repeat (4) @(posedge pclk);
      chk_val({31'h0, lnk.fault_n}, 32'h0);
      chk_val(rq.size(), 32'h0);
      xfer(RD, FS, 14'h0, E_FLT | 21'h40, KM | 21'h40);
      daisy_mode <= 1'b0;
   endtask : wdog
   initial
   begin
      #300000;
      fails++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      close_out();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {daisy_mode, fault_event, above_rsp, above_commfail, scan_done} = '0;
      top_device = 1'b1;
      {fails, samples_checked, idle_cnt} = '0;
      n = $urandom(32'h2082);
      rst();
      repeat (40) @(posedge pclk);
      chk_val({31'h0, sleeping}, 32'h0);
      xfer(WR, WB, 14'h0000, E_ACK, KM);
      xfer(RD, WB, 14'h0, E_DAT | 21'h1, KM | 21'h7f);
      xfer(WR, dcf_pkg::REG_DEVICE_SETUP, {6'h3a, 8'h00}, E_ACK, KM);
      xfer(WR, WB, 14'h0000, E_ACK, KM);
      xfer(RD, WB, 14'h0, E_DAT, KM | 21'h7f);
      daisy_mode <= 1'b1;
      repeat (40) @(posedge pclk);
      chk_val({31'h0, sleeping}, 32'h0);
      daisy_mode <= 1'b0;
      // Random run of scans and measures, some while one is busy
      rst();
      sc = 0;
      n = 17 + $urandom_range(0, 4);
      repeat (n)
      begin
         cmd(($urandom_range(0, 1) != 0) ? dcf_pkg::DCF_CMD_SCAN :
            dcf_pkg::DCF_CMD_MEASURE, 6'h00, 14'h0);
         er = 1'($urandom_range(0, 1));
         scan_done <= er;
         @(posedge pclk);
         scan_done <= 1'b0;
         sc++;
      end
      @(posedge pclk);
      chk_val({31'h0, scan_busy}, {31'h0, !er});
      chk_val({28'h0, scan_count}, sc % 16);
      xfer(RD, SCN, 14'h0, E_DAT | (sc % 16), KM | 21'hf);
      // Fault pending, cleared, then raised again
      fault_event <= 1'b1;
      @(posedge pclk);
      fault_event <= 1'b0;
      repeat (4) @(posedge pclk);
      chk_val({31'h0, lnk.fault_n}, 32'h0);
      chk_rsp(E_FLT | 21'h1, KM | 21'h3fff);
      xfer(RD, SCN, 14'h0, E_FLT | (sc % 16), KM | 21'hf);
      xfer(WR, WB, 14'h0007, E_FLT, KM);
      cmd(dcf_pkg::DCF_CMD_ACTION, 6'h00, 14'h0);
      repeat (20) @(posedge pclk);
      chk_val(rq.size(), 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk_val(rd & 32'h1, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk_val({29'h0, rd[20:18]}, 32'(dcf_pkg::DCF_RSP_FAULT));
      apb(1'b0, 8'h0c, 32'h0);
      chk_val({31'h0, er}, 32'h1);
      xfer(WR, dcf_pkg::REG_FAULT_DATA, 14'h0, E_FLT, KM);
      xfer(WR, FS, 14'h0, E_ACK, KM);
      repeat (4) @(posedge pclk);
      chk_val({31'h0, lnk.fault_n}, 32'h1);
      xfer(RD, SCN, 14'h0, E_DAT, KM);
      fault_event <= 1'b1;
      @(posedge pclk);
      fault_event <= 1'b0;
      repeat (4) @(posedge pclk);
      chk_rsp(E_FLT | 21'h1, KM | 21'h3fff);
      xfer(RD, SCN, 14'h0, E_FLT, KM);
      // Lower stack position: timeout, answer from above, relayed failure
      top_device <= 1'b0;
      rst();
      xfer(RD, SCN, 14'h0, E_CF, KM | AM);
      n = $urandom_range(0, 1);
      repeat (2)
      begin
         cmd(RD, WB, 14'h0);
         above_rsp <= (n == 0);
         above_commfail <= (n != 0);
         @(posedge pclk);
         above_rsp <= 1'b0;
         above_commfail <= 1'b0;
         chk_rsp(((n != 0) ? E_CF : E_DAT) | 21'h1, KM | 21'h3fff);
         n = 1 - n;
      end
      chk_val(32'(idle_cnt > 0), 32'h1);
      top_device <= 1'b1;
      wdog(7'h03, 30);
      wdog(7'h40, 1200);
      n = $urandom_range(1, 6);
      wdog(7'(n), n * 10);
      close_out();
   end
endmodule : tb
